// *** rtl/fc_host_pkg.sv ***
// constants, encodings and state types shared by the card host controller
package fc_host_pkg;
	// ------------------------------------------------------------
	// clock rate and access timing (plain defaults)
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int SETUP_NS = 30; // address to strobe
	localparam int STROBE_NS = 165; // strobe low time
	localparam int HOLD_NS = 20; // strobe release to address change
	localparam int BEAT_NS = 60; // data-out setup before a strobe edge
	// least times round up to whole cycles
	localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int BEAT_CYC = (BEAT_NS * CLK_MHZ + 999) / 1000;
	localparam logic [4:0] SETUP_CNT = 5'(SETUP_CYC);
	localparam logic [4:0] STROBE_CNT = 5'(STROBE_CYC);
	localparam logic [4:0] HOLD_CNT = 5'(HOLD_CYC);
	localparam logic [4:0] BEAT_CNT = 5'(BEAT_CYC);
	// ------------------------------------------------------------
	// access widths, addresses and buffering
	// ------------------------------------------------------------
	localparam logic [1:0] WID_BYTE = 2'h0; // a0 picks even or odd byte
	localparam logic [1:0] WID_WORD = 2'h1; // both enables low
	localparam logic [1:0] WID_ODD = 2'h2; // odd byte on upper lane
	localparam logic [2:0] ADDR_DATA = 3'h0; // pio data word register
	localparam int FIFO_WIDTH = 16;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] PAUSE_LEVEL = 4'h4; // leaves room for late words
	// ------------------------------------------------------------
	// state machines
	// ------------------------------------------------------------
	typedef enum logic [7:0] {
		U_IDLE = 8'h01, U_PREP = 8'h02, U_ACK = 8'h04, U_BURST = 8'h08,
		U_TERM = 8'h10, U_DEVEND = 8'h20, U_ALIGN = 8'h40, U_CRC = 8'h80
	} udma_state_t;
	typedef enum logic [3:0] {
		A_IDLE = 4'h1, A_SETUP = 4'h2, A_STROBE = 4'h4, A_HOLD = 4'h8
	} acc_state_t;
endpackage

// *** rtl/fc_host.sv ***
// host controller for a flash card bus: ultra dma bursts, memory and ide accesses
// What this block does
// - host prepares, acknowledges, then starts burst
// - host pauses data-in by negating ready
// - host pauses data-out by holding strobe
// - host answers card end with stop
// - card answers host stop by dropping request
// - crc passes on acknowledge edge, lines idle
// - ide mode only if oe held low
`timescale 1ns/100ps

// ------------------------------------------------------------
// fifo with parameterised width and depth
// ------------------------------------------------------------
module fc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// fill level
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW-1:0] wptr; // next slot to write
	logic [AW-1:0] rptr; // next slot to read
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = level != (AW+1)'(DEPTH);
	assign out_valid = level != '0;
	assign out_data = mem[rptr];
	// pointers and level
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wptr <= '0;
			rptr <= '0;
			level <= '0;
		end else begin
			wptr <= push ? AW'(wptr + 1'b1) : wptr;
			rptr <= pop ? AW'(rptr + 1'b1) : rptr;
			level <= (AW+1)'(level + push - pop);
		end
	end
	// storage has no reset; level guards reads
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wptr] <= in_data;
		end
	end
endmodule

// ------------------------------------------------------------
// top: card host controller
// ------------------------------------------------------------
module fc_host (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// single access request
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [1:0] acc_width,
	input wire logic acc_ctrl,
	input wire logic [10:0] acc_addr,
	input wire logic [15:0] acc_wdata,
	output logic acc_done,
	output logic [15:0] acc_rdata,
	// ultra dma control
	input wire logic dma_go,
	input wire logic dma_read,
	input wire logic dma_stop,
	output logic dma_busy,
	input wire logic [15:0] crc_in,
	output logic [15:0] crc_word,
	output logic crc_valid,
	// data-out stream
	input wire logic [15:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	// data-in stream
	output logic [15:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready,
	// mode and power
	input wire logic ide_select,
	output logic ide_mode,
	output logic card_power,
	// card pins
	output logic ce1_n,
	output logic ce2_n,
	output logic reg_n,
	output logic oe_n,
	output logic we_n,
	output logic hioe_n,
	output logic hiow_n,
	output logic [10:0] addr,
	input wire logic [15:0] data_i,
	output logic [15:0] data_o,
	output logic data_oe,
	input wire logic wait_n,
	input wire logic inpack_n
);
	// ------------------------------------------------------------
	// pin synchronisers and state
	// ------------------------------------------------------------
	logic wait_m, wait_s, wait_q; // card strobe or ready
	logic pack_m, pack_s; // card request
	logic [15:0] data_m, data_s; // card data
	fc_host_pkg::udma_state_t udma, next_udma;
	fc_host_pkg::acc_state_t acc, next_acc;
	logic [4:0] acnt; // access phase counter
	logic [4:0] bcnt; // burst beat counter
	logic hstrobe; // host data-out strobe level
	logic [15:0] wbuf; // word on the bus in data-out
	logic started; // mode captured after release
	logic a_write, a_ce1_n, a_ce2_n, a_word, a_odd; // latched access
	logic [10:0] a_addr;
	logic [15:0] a_wdata;
	logic next_ce1_n, next_ce2_n, next_reg_n, next_oe_n, next_we_n;
	logic next_hioe_n, next_hiow_n, next_oe;
	logic [15:0] next_dout;
	logic [3:0] fifo_level;
	logic fifo_in_ready;
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire dmarq = !pack_s; // request is active low on the pin
	wire card_strobe_edge = wait_s != wait_q;
	wire card_rdy = !wait_s; // data-out ready from the card
	wire in_burst = udma == fc_host_pkg::U_BURST;
	wire rd_phase = dma_read && (in_burst || udma == fc_host_pkg::U_TERM
		|| udma == fc_host_pkg::U_DEVEND);
	wire push = rd_phase && card_strobe_edge;
	wire host_pause = fifo_level >= fc_host_pkg::PAUSE_LEVEL;
	wire take = wr_ready && wr_valid;
	// ide: data register at 0 is a word, control block picks cs1
	wire ide_word = !acc_ctrl && acc_addr[2:0] == fc_host_pkg::ADDR_DATA;
	wire mem_word = acc_width == fc_host_pkg::WID_WORD;
	wire mem_odd = acc_width == fc_host_pkg::WID_ODD;
	wire d_word = ide_mode ? ide_word : mem_word;
	wire d_odd = !ide_mode && mem_odd;
	// in ide mode only one chip select low; dma acknowledge never joins it
	wire d_ce1_n = ide_mode ? acc_ctrl : d_odd;
	wire d_ce2_n = ide_mode ? !acc_ctrl : !(d_odd || d_word);
	wire acc_take = acc == fc_host_pkg::A_IDLE && acc_req && udma == fc_host_pkg::U_IDLE
		&& card_power;
	wire udma_start = dma_go && dmarq && !ide_mode && acc == fc_host_pkg::A_IDLE
		&& !acc_req && card_power;
	wire acnt_end = acnt == 5'h01;
	wire [15:0] steer_rd = a_word ? data_s : {8'h00, a_odd ? data_s[15:8] : data_s[7:0]};
	wire next_wr_ready = next_udma == fc_host_pkg::U_BURST && !dma_read && bcnt == 5'h00
		&& !take && card_rdy && !dma_stop;
	// ------------------------------------------------------------
	// synchronisers: first stage feeds only the second
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			{wait_m, wait_s, wait_q} <= 3'h7;
			{pack_m, pack_s} <= 2'h3;
			data_m <= 16'h0000;
			data_s <= 16'h0000;
		end else begin
			{wait_m, wait_s, wait_q} <= {wait_n, wait_m, wait_s};
			{pack_m, pack_s} <= {inpack_n, pack_m};
			data_m <= data_i;
			data_s <= data_m;
		end
	end
	// ------------------------------------------------------------
	// mode strap and power sequencing
	// ------------------------------------------------------------
	// mode is caught after release, power follows one edge after oe settles
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			started <= 1'b0;
			ide_mode <= 1'b0;
			card_power <= 1'b0;
		end else begin
			started <= 1'b1;
			ide_mode <= started ? ide_mode : ide_select;
			// latched once on: a memory read strobe must not cut the supply
			card_power <= card_power || (started && oe_n == !ide_mode);
		end
	end
	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_acc = acc;
		case (acc)
			fc_host_pkg::A_IDLE: next_acc = acc_take ? fc_host_pkg::A_SETUP : acc;
			fc_host_pkg::A_SETUP: next_acc = acnt_end ? fc_host_pkg::A_STROBE : acc;
			fc_host_pkg::A_STROBE: next_acc = acnt_end ? fc_host_pkg::A_HOLD : acc;
			fc_host_pkg::A_HOLD: next_acc = acnt_end ? fc_host_pkg::A_IDLE : acc;
			default: next_acc = fc_host_pkg::A_IDLE;
		endcase
	end
	// counter, latched request and read data
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			acc <= fc_host_pkg::A_IDLE;
			acnt <= 5'h00;
			{a_write, a_word, a_odd, a_ce1_n, a_ce2_n} <= 5'h03;
			a_addr <= 11'h000;
			a_wdata <= 16'h0000;
			acc_rdata <= 16'h0000;
			acc_done <= 1'b0;
		end else begin
			acc <= next_acc;
			acc_done <= acc == fc_host_pkg::A_HOLD && acnt_end;
			if (acc_take) begin
				{a_write, a_word, a_odd, a_ce1_n, a_ce2_n} <=
					{acc_write, d_word, d_odd, d_ce1_n, d_ce2_n};
				a_addr <= acc_addr;
				a_wdata <= acc_wdata;
				acnt <= fc_host_pkg::SETUP_CNT;
			end else if (acc == fc_host_pkg::A_SETUP && acnt_end) begin
				acnt <= fc_host_pkg::STROBE_CNT;
			end else if (acc == fc_host_pkg::A_STROBE && acnt_end) begin
				acnt <= fc_host_pkg::HOLD_CNT;
				acc_rdata <= a_write ? acc_rdata : steer_rd;
			end else if (acnt != 5'h00) begin
				acnt <= 5'(acnt - 1'b1);
			end
		end
	end
	// ------------------------------------------------------------
	// ultra dma sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_udma = udma;
		case (udma)
			// card has raised its request before we acknowledge
			fc_host_pkg::U_IDLE: next_udma = udma_start ? fc_host_pkg::U_PREP : udma;
			fc_host_pkg::U_PREP: next_udma = fc_host_pkg::U_ACK;
			fc_host_pkg::U_ACK: next_udma = fc_host_pkg::U_BURST;
			fc_host_pkg::U_BURST: begin
				if (!dmarq) begin
					next_udma = fc_host_pkg::U_DEVEND;
				end else if (dma_stop && bcnt == 5'h00) begin
					next_udma = fc_host_pkg::U_TERM;
				end
			end
			// card drops its request to answer our stop
			fc_host_pkg::U_TERM: next_udma = dmarq ? udma : fc_host_pkg::U_ALIGN;
			fc_host_pkg::U_DEVEND: next_udma = fc_host_pkg::U_ALIGN;
			// in data-in the card strobe must reach its asserted level
			fc_host_pkg::U_ALIGN: begin
				next_udma = (!dma_read || wait_s) ? fc_host_pkg::U_CRC : udma;
			end
			fc_host_pkg::U_CRC: next_udma = bcnt == 5'h00 ? fc_host_pkg::U_IDLE : udma;
			default: next_udma = fc_host_pkg::U_IDLE;
		endcase
	end
	// beat counter, host strobe, stream handshakes and crc
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			udma <= fc_host_pkg::U_IDLE;
			bcnt <= 5'h00;
			hstrobe <= 1'b1;
			wbuf <= 16'h0000;
			wr_ready <= 1'b0;
			crc_word <= 16'h0000;
			crc_valid <= 1'b0;
			dma_busy <= 1'b0;
		end else begin
			udma <= next_udma;
			wr_ready <= next_wr_ready;
			dma_busy <= next_udma != fc_host_pkg::U_IDLE;
			crc_valid <= udma == fc_host_pkg::U_CRC && bcnt == 5'h00;
			if (udma == fc_host_pkg::U_CRC && bcnt == 5'h00 && dma_read) begin
				crc_word <= data_s;
			end
			if (udma == fc_host_pkg::U_PREP) begin
				hstrobe <= 1'b1;
			end else if (in_burst && !dma_read && bcnt == 5'h01) begin
				hstrobe <= !hstrobe; // word stands BEAT_CNT cycles first
			end
			if (take) begin
				wbuf <= wr_data;
				bcnt <= fc_host_pkg::BEAT_CNT;
			end else if (udma == fc_host_pkg::U_ALIGN && next_udma == fc_host_pkg::U_CRC) begin
				wbuf <= crc_in;
				bcnt <= fc_host_pkg::BEAT_CNT;
			end else if (bcnt != 5'h00) begin
				bcnt <= 5'(bcnt - 1'b1);
			end
		end
	end
	// ------------------------------------------------------------
	// next pin levels from both sequencers
	// ------------------------------------------------------------
	always_comb begin
		next_ce1_n = 1'b1;
		next_ce2_n = 1'b1;
		next_reg_n = ide_mode; // dmack stays idle in ide mode
		next_oe_n = !ide_mode; // held grounded to keep ide mode
		next_we_n = 1'b1;
		next_hioe_n = 1'b1;
		next_hiow_n = 1'b1;
		next_oe = 1'b0;
		next_dout = data_o;
		if (acc != fc_host_pkg::A_IDLE) begin
			next_ce1_n = a_ce1_n;
			next_ce2_n = a_ce2_n;
			next_reg_n = 1'b1;
			next_oe = a_write;
			next_dout = a_word ? a_wdata : {a_wdata[7:0], a_wdata[7:0]};
			if (acc == fc_host_pkg::A_STROBE && ide_mode) begin
				next_hioe_n = a_write;
				next_hiow_n = !a_write;
			end else if (acc == fc_host_pkg::A_STROBE) begin
				next_oe_n = a_write;
				next_we_n = !a_write;
			end
		end
		case (udma)
			fc_host_pkg::U_ACK: next_reg_n = 1'b1;
			fc_host_pkg::U_BURST: begin
				next_reg_n = 1'b1;
				next_hiow_n = 1'b0;
				next_hioe_n = dma_read ? host_pause : hstrobe;
				next_oe = !dma_read;
				next_dout = wbuf;
			end
			fc_host_pkg::U_TERM, fc_host_pkg::U_DEVEND: begin
				next_reg_n = 1'b1;
				next_hioe_n = dma_read ? 1'b1 : hstrobe;
				next_oe = !dma_read;
				next_dout = wbuf;
			end
			fc_host_pkg::U_ALIGN, fc_host_pkg::U_CRC: begin
				next_reg_n = !(udma == fc_host_pkg::U_CRC && bcnt == 5'h00);
				next_oe = !dma_read;
				next_dout = wbuf;
			end
			default: next_reg_n = next_reg_n;
		endcase
	end
	// every pin comes from a flip-flop
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			{ce1_n, ce2_n, reg_n, oe_n, we_n, hioe_n, hiow_n} <= 7'h6f;
			addr <= 11'h000;
			data_o <= 16'h0000;
			data_oe <= 1'b0;
		end else begin
			{ce1_n, ce2_n, reg_n, oe_n, we_n} <=
				{next_ce1_n, next_ce2_n, next_reg_n, next_oe_n, next_we_n};
			{hioe_n, hiow_n} <= {next_hioe_n, next_hiow_n};
			addr <= acc == fc_host_pkg::A_IDLE ? addr : a_addr;
			data_o <= next_dout;
			data_oe <= next_oe;
		end
	end
	// ------------------------------------------------------------
	// data-in buffer
	// ------------------------------------------------------------
	fc_fifo #(.WIDTH(fc_host_pkg::FIFO_WIDTH), .DEPTH(fc_host_pkg::FIFO_DEPTH)) rx_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(data_s),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data),
		.level(fifo_level)
	);
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	ack_prepare_a: assert property (@(posedge clock) disable iff (reset)
		udma == fc_host_pkg::U_PREP |=> hiow_n && ce1_n && ce2_n && !reg_n ##1 reg_n && hiow_n
		##1 !hiow_n) else $error("acknowledge order broken");
	read_pause_a: assert property (@(posedge clock) disable iff (reset)
		(in_burst && dma_read && next_udma == fc_host_pkg::U_BURST && host_pause) |=> hioe_n)
		else $error("host ready not negated on full buffer");
	write_hold_a: assert property (@(posedge clock) disable iff (reset)
		(in_burst && !dma_read && bcnt == 5'h00 && !take) [*2] |=> $stable(hioe_n))
		else $error("host strobe moved without data");
	dev_end_a: assert property (@(posedge clock) disable iff (reset)
		udma == fc_host_pkg::U_DEVEND && dma_read |=> hiow_n && hioe_n && reg_n)
		else $error("device termination not answered");
	host_end_a: assert property (@(posedge clock) disable iff (reset)
		(in_burst && next_udma == fc_host_pkg::U_TERM) |-> ##2 (hiow_n
		&& (hioe_n || !dma_read))) else $error("stop not asserted");
	crc_edge_a: assert property (@(posedge clock) disable iff (reset)
		$fell(reg_n) && !ide_mode && $past(udma) == fc_host_pkg::U_CRC |-> hiow_n && hioe_n
		&& ce1_n && ce2_n) else $error("acknowledge edge with lines not idle");
	ide_strap_a: assert property (@(posedge clock) disable iff (reset)
		card_power |-> (!oe_n || !ide_mode) && $stable(ide_mode))
		else $error("oe released while powered in ide mode");
	chip_sel_a: assert property (@(posedge clock) disable iff (reset)
		ide_mode && card_power |-> (ce1_n || ce2_n) && reg_n)
		else $error("chip selects or dma mixed");
endmodule

// *** dv/fc_card_model.sv ***
// behavioural flash card answering the host controller's pins
`timescale 1ns/100ps
module fc_card_model #(
	parameter logic [15:0] MEM_WORD = 16'ha55a,
	parameter logic [15:0] IDE_WORD = 16'hc3e1,
	parameter logic [15:0] CRC_WORD = 16'h6b2d,
	parameter logic [7:0] ALT_STATUS = 8'h50,
	parameter logic [7:0] DRIVE_ADDR = 8'h7e
) (
	// clock and supply
	input wire logic clock,
	input wire logic card_power,
	// host driven pins
	input wire logic ce1_n,
	input wire logic ce2_n,
	input wire logic reg_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic hioe_n,
	input wire logic hiow_n,
	input wire logic [10:0] addr,
	input wire logic [15:0] data_o,
	// card driven pins
	output logic [15:0] data_i,
	output logic wait_n,
	output logic inpack_n,
	// burst control from the bench
	input wire logic burst_go,
	input wire logic [7:0] burst_words,
	input wire logic [7:0] burst_pace,
	input wire logic burst_out,
	output logic [15:0] last_wr
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic ide; // mode caught when the supply comes up
	logic bursting; // card owns the data lines
	logic [15:0] bdata; // word or check word offered in a burst
	logic seen; // last host strobe level seen in data-out
	int low_run; // cycles the select pin has stayed low

	// mode is chosen from the select pin whenever the supply comes up after a reset
	always @(posedge card_power)
		ide = !oe_n;

	// always-on watch: a high select leaves ide, a long low one enters it
	always @(posedge clock) begin
		low_run <= oe_n ? 0 : low_run + 1;
		if (card_power && ide && oe_n)
			ide = 1'b0;
		else if (card_power && low_run > 200)
			ide = 1'b1;
	end

	// released lanes flip every cycle so a stale value is never read as good
	always @(posedge clock) begin
		data_i <= ~data_i;
		if (bursting)
			data_i <= bdata;
		else if (!ide && reg_n && !oe_n) begin
			case ({ce2_n, ce1_n})
				2'b00: data_i <= MEM_WORD;
				2'b10: data_i[7:0] <= addr[0] ? MEM_WORD[15:8] : MEM_WORD[7:0];
				2'b01: data_i[15:8] <= MEM_WORD[15:8];
				default: ;
			endcase
		end else if (ide && !hioe_n && !ce1_n && ce2_n) begin
			if (addr[2:0] == 3'h0)
				data_i <= IDE_WORD;
			else
				data_i[7:0] <= 8'h30 + 8'(addr[2:0]);
		end else if (ide && !hioe_n && ce1_n && !ce2_n)
			data_i[7:0] <= (addr[2:0] == 3'h6) ? ALT_STATUS : DRIVE_ADDR;
	end

	// word writes are remembered for the bench to inspect
	always @(posedge we_n)
		if (!ce1_n && !ce2_n)
			last_wr <= data_o;

	// burst either way: request, words on strobe edges, end, align, check word in data-in
	initial begin
		data_i = 16'h0;
		last_wr = 16'h0;
		ide = 1'b0;
		inpack_n = 1'b1;
		wait_n = 1'b1;
		bursting = 1'b0;
		bdata = 16'h0;
		seen = 1'b1;
		low_run = 0;
		forever begin
			@(posedge burst_go);
			@(posedge clock);
			inpack_n <= 1'b0;
			while (!(reg_n && !hiow_n))
				@(posedge clock);
			seen = hioe_n;
			if (burst_out)
				wait_n <= 1'b0;
			else
				bursting <= 1'b1;
			// data-out: count host strobe edges, then the card ends the burst
			for (int i = 0; burst_out && i < int'(burst_words); ) begin
				@(posedge clock);
				if (hioe_n != seen)
					i++;
				seen = hioe_n;
			end
			for (int i = 0; !burst_out && i < int'(burst_words) && !hiow_n; i++) begin
				// a paused host gets no strobe edge
				while (hioe_n && !hiow_n)
					@(posedge clock);
				if (hiow_n)
					break;
				bdata <= 16'h1000 + 16'(i);
				repeat (2) @(posedge clock);
				wait_n <= ~wait_n;
				repeat (burst_pace) @(posedge clock);
			end
			inpack_n <= 1'b1;
			while (!hiow_n)
				@(posedge clock);
			wait_n <= 1'b1;
			bdata <= CRC_WORD;
			while (reg_n)
				@(posedge clock);
			bursting <= 1'b0;
		end
	end
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the card host controller and its buffer
`timescale 1ns/100ps
module testbench;
	// ------------------------------------------------------------
	// signals, card contents and counters
	// ------------------------------------------------------------
	localparam logic [15:0] MEM_WORD = 16'ha55a; // common memory word
	localparam logic [15:0] IDE_WORD = 16'hc3e1; // ide data register
	localparam logic [15:0] CRC_WORD = 16'h6b2d; // burst check word
	localparam logic [7:0] ALT_STATUS = 8'h50; // alternate status byte
	localparam logic [7:0] DRIVE_ADDR = 8'h7e; // drive address byte
	logic clock, reset, acc_req, acc_write, acc_ctrl, acc_done, dma_go, dma_stop, dma_busy;
	logic crc_valid, wr_ready, rd_valid, rd_ready, ide_select, ide_mode, card_power, burst_go;
	logic ce1_n, ce2_n, reg_n, oe_n, we_n, hioe_n, hiow_n, data_oe, wait_n, inpack_n, paused;
	logic [1:0] acc_width, pins;
	logic [10:0] acc_addr, addr;
	logic [15:0] acc_wdata, acc_rdata, crc_word, rd_data, data_i, data_o, last_wr, r;
	logic [7:0] burst_words, burst_pace;
	logic dma_read, hioe_q, wr_valid; // burst direction, last host strobe, data-out offer
	logic [15:0] wr_data; // next data-out word
	int errors, total_checks, got;

	// both burst directions run against the card model
	fc_host fc_host_inst (
		.clock, .reset, .acc_req, .acc_write, .acc_width, .acc_ctrl, .acc_addr, .acc_wdata,
		.acc_done, .acc_rdata, .dma_go, .dma_read, .dma_stop, .dma_busy,
		.crc_in(CRC_WORD), .crc_word, .crc_valid, .wr_data, .wr_valid, .wr_ready,
		.rd_data, .rd_valid, .rd_ready, .ide_select, .ide_mode, .card_power, .ce1_n, .ce2_n,
		.reg_n, .oe_n, .we_n, .hioe_n, .hiow_n, .addr, .data_i, .data_o, .data_oe, .wait_n,
		.inpack_n
	);
	fc_card_model #(.MEM_WORD(MEM_WORD), .IDE_WORD(IDE_WORD), .CRC_WORD(CRC_WORD),
		.ALT_STATUS(ALT_STATUS), .DRIVE_ADDR(DRIVE_ADDR)) fc_card_model_inst (
		.clock, .card_power, .ce1_n, .ce2_n, .reg_n, .oe_n, .we_n, .hioe_n, .hiow_n, .addr,
		.data_o, .data_i, .wait_n, .inpack_n, .burst_go, .burst_words, .burst_pace,
		.burst_out(!dma_read), .last_wr
	);

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wait_expired();
		errors++;
		$display("unexpected at %0t: wait ran out", $time);
		finish_test();
	endtask

	// reset with a chosen mode strap, then let the supply come up
	task automatic restart(input logic sel);
		ide_select <= sel;
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		repeat (6) @(posedge clock);
	endtask

	// one access; request dropped once the enables show it was taken
	task automatic access(input logic wr, input logic ctl, input logic [1:0] wid,
			input logic [10:0] a, input logic [15:0] wd, output logic [15:0] rd);
		int n;
		acc_write <= wr;
		acc_ctrl <= ctl;
		acc_width <= wid;
		acc_addr <= a;
		acc_wdata <= wd;
		acc_req <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(negedge clock);
			if (!we_n || !hioe_n || !hiow_n || (!oe_n && !ide_mode))
				pins = {ce2_n, ce1_n};
			if (acc_done === 1'b1)
				break;
			@(posedge clock);
			if (!ce1_n || !ce2_n)
				acc_req <= 1'b0;
		end
		if (n == 60)
			wait_expired();
		rd = acc_rdata;
		@(posedge clock);
	endtask

	// one cycle: take a data-in word at mid-cycle, return on the rising edge
	task automatic step();
		@(negedge clock);
		if (rd_valid === 1'b1 && rd_ready) begin
			check(rd_data, 16'h1000 + 16'(got));
			got++;
		end
		// data-out: each host strobe edge inside the burst carries the next word
		if (!dma_read && reg_n && !hiow_n && hioe_n !== hioe_q) begin
			check(data_o, 16'h2000 + 16'(got));
			got++;
		end
		hioe_q = hioe_n;
		@(posedge clock);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic mem_scenario();
		access(1'b0, 1'b0, fc_host_pkg::WID_WORD, 11'h0, 16'h0, r);
		check(r, MEM_WORD);
		check({14'h0, pins}, 16'h0);
		access(1'b0, 1'b0, fc_host_pkg::WID_BYTE, 11'h1, 16'h0, r);
		check(r, {8'h0, MEM_WORD[15:8]});
		check({14'h0, pins}, 16'h2);
		access(1'b0, 1'b0, fc_host_pkg::WID_BYTE, 11'h2, 16'h0, r);
		check(r, {8'h0, MEM_WORD[7:0]});
		access(1'b0, 1'b0, fc_host_pkg::WID_ODD, 11'h3, 16'h0, r);
		check({14'h0, pins}, 16'h1);
		access(1'b1, 1'b0, fc_host_pkg::WID_WORD, 11'h4, 16'h3c96, r);
		check(last_wr, 16'h3c96);
	endtask

	// burst in the direction rd picks; stall holds the drain side, stop ends it from the host
	task automatic udma(input int words, input int pace, input int stall, input logic stop,
			input logic rd);
		int n;
		dma_read <= rd;
		burst_words <= 8'(words);
		burst_pace <= 8'(pace);
		rd_ready <= (stall == 0);
		dma_go <= 1'b1;
		burst_go <= 1'b1;
		got = 0;
		paused = 1'b0;
		for (n = 0; n < 3000 && crc_valid !== 1'b1; n++) begin
			step();
			burst_go <= 1'b0;
			if (wr_ready && wr_valid)
				wr_data <= wr_data + 16'h1;
			wr_valid <= !rd && (n < 20 || n > 30);
			if (n == stall)
				rd_ready <= 1'b1;
			if (stop && got > 1)
				dma_stop <= 1'b1;
			if (reg_n && !hiow_n) begin
				paused |= hioe_n;
				check({14'h0, ce2_n, ce1_n}, 16'h3);
			end
		end
		if (n == 3000)
			wait_expired();
		repeat (6) step();
		check(rd ? crc_word : data_o, CRC_WORD);
		check({13'h0, reg_n, hiow_n, hioe_n}, 16'h3);
		check(16'(stop ? got > 1 && got < words : got == words), 16'h1);
		if (stall > 0)
			check(16'(paused), 16'h1);
		dma_go <= 1'b0;
		dma_stop <= 1'b0;
		wr_valid <= 1'b0;
		repeat (3) step();
		check(16'(dma_busy), 16'h0);
	endtask

	task automatic ide_scenario();
		restart(1'b1);
		check({13'h0, ide_mode, oe_n, card_power}, 16'h5);
		access(1'b0, 1'b0, fc_host_pkg::WID_BYTE, 11'h3, 16'h0, r);
		check(r, 16'h0033);
		check({14'h0, pins}, 16'h2);
		access(1'b0, 1'b0, fc_host_pkg::WID_WORD, 11'h0, 16'h0, r);
		check(r, IDE_WORD);
		access(1'b0, 1'b1, fc_host_pkg::WID_BYTE, 11'h6, 16'h0, r);
		check(r, {8'h0, ALT_STATUS});
		check({14'h0, pins}, 16'h1);
		access(1'b0, 1'b1, fc_host_pkg::WID_BYTE, 11'h7, 16'h0, r);
		check(r, {8'h0, DRIVE_ADDR});
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		reset = 1'b1;
		{acc_req, acc_write, acc_ctrl, dma_go, dma_stop, rd_ready, ide_select} = 7'h0;
		{burst_go, paused, acc_width, pins} = 5'h0;
		{dma_read, hioe_q, wr_valid} = 3'h6;
		wr_data = 16'h2000;
		{acc_addr, acc_wdata, burst_words, burst_pace} = 43'h0;
		errors = 0;
		total_checks = 0;
		got = 0;
		restart(1'b0);
		check({14'h0, ide_mode, oe_n}, 16'h1);
		mem_scenario();
		udma(4, 3, 0, 1'b0, 1'b1);
		udma(8, 3, 200, 1'b0, 1'b1);
		udma(12, 8, 0, 1'b1, 1'b1);
		udma(6, 0, 0, 1'b0, 1'b0);
		ide_scenario();
		finish_test();
	end
endmodule
